// ### design/dbg_pkg.sv
package dbg_pkg;

   // command codes
   localparam logic [7:0] CMD_REV        = 8'h00;
   localparam logic [7:0] CMD_STAT       = 8'h02;
   localparam logic [7:0] CMD_RUNTIME    = 8'h03;
   localparam logic [7:0] CMD_CTL_WR     = 8'h04;
   localparam logic [7:0] CMD_CTL_RD     = 8'h05;
   localparam logic [7:0] CMD_PGM_WR     = 8'h0A;
   localparam logic [7:0] CMD_PGM_RD     = 8'h0B;
   localparam logic [7:0] CMD_DAT_WR     = 8'h0C;
   localparam logic [7:0] CMD_DAT_RD     = 8'h0D;
   localparam logic [7:0] CMD_STUFF      = 8'h11;
   localparam logic [7:0] CMD_EXEC       = 8'h12;
   localparam logic [7:0] CMD_RSVD_FIRST = 8'h13;

   // control byte layout and reset
   localparam int         HALT_BIT  = 7;
   localparam logic [7:0] CTL_RESET = 8'h00;

   // runtime counter bounds
   localparam logic [15:0] RUNTIME_START = 16'h0000;
   localparam logic [15:0] RUNTIME_MAX   = 16'hFFFF;

   // memory block transfers
   localparam logic [2:0]  MEM_ARG_LAST  = 3'h3;
   localparam logic [16:0] MEM_MAX_COUNT = 17'h10000;
   localparam logic [7:0]  BLANK_BYTE    = 8'hFF;

   // reply lengths in bytes
   localparam logic [1:0] REPLY_ONE = 2'h1;
   localparam logic [1:0] REPLY_TWO = 2'h2;

   localparam int RESP_FIFO_DEPTH = 4;
   localparam int RESP_FIFO_WIDTH = 8;

   // request towards program or data memory
   typedef struct packed {
      logic        req;
      logic        space_data;
      logic        we;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } mem_req_t;

endpackage

// ### design/resp_fifo.sv
`timescale 1ns/1ps
module resp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clock_i,
   input  wire logic             rstn_i,
   input  wire logic             ce_i,
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   output logic                  out_valid_o,
   output logic [WIDTH-1:0]      out_data_o,
   input  wire logic             out_ready_i
);

   logic             valid_r [DEPTH];
   logic [WIDTH-1:0] data_r  [DEPTH];
   logic [DEPTH-1:0] sh_v;
   logic [WIDTH-1:0] sh_d    [DEPTH];
   logic             push_w;
   logic             pop_w;

   assign in_ready_o  = !valid_r[DEPTH-1];
   assign out_valid_o = valid_r[0];
   assign out_data_o  = data_r[0];
   assign push_w      = in_valid_i && in_ready_o && ce_i;
   assign pop_w       = out_ready_i && valid_r[0] && ce_i;

   ////////////////////////////////////////////////////////////////////////////
   // head sits in slot 0; a pop shifts every slot down by one
   for (genvar i = 0; i < DEPTH; i++) begin : g_slot
      logic below_v;
      if (i == DEPTH-1) begin : g_top
         assign sh_v[i] = valid_r[i] && !pop_w;
         assign sh_d[i] = data_r[i];
      end else begin : g_mid
         assign sh_v[i] = pop_w ? valid_r[i+1] : valid_r[i];
         assign sh_d[i] = pop_w ? data_r[i+1] : data_r[i];
      end
      if (i == 0) begin : g_first
         assign below_v = 1'b1;
      end else begin : g_rest
         assign below_v = sh_v[i-1];
      end

      always_ff @(posedge clock_i) begin
         if (!rstn_i) begin
            valid_r[i] <= 1'b0;
            data_r[i]  <= '0;
         end else if (ce_i) begin
            if (push_w && !sh_v[i] && below_v) begin
               valid_r[i] <= 1'b1;
               data_r[i]  <= in_data_i;
            end else begin
               valid_r[i] <= sh_v[i];
               data_r[i]  <= sh_d[i];
            end
         end
      end
   end

endmodule

// ### design/debug_command_interpreter.sv
// Notes on behaviour
// - 11H stuffs and 12H executes an instruction, both refused under read protection; 13H-FFH reserved.
// - the host sends a command byte and its operands first, then reply bytes flow back.
// - 00H returns the revision word, major byte first, minor byte second.
// - 02H returns one byte with the current debug status byte.
// - the runtime counter is 16 bits, counts up from 0000H each clock and sticks at FFFFH.
// - the counter times cycles between breakpoints and 03H returns it high byte first.
// - memory commands overwrite the counter, and so do stuff and execute unless read protected.
// - 04H takes exactly one more byte and loads it into the debug control byte.
// - under read protection the halt flag may be set but never cleared; only reset clears it.
// - 05H returns one byte with the current debug control byte.
// - 0AH takes all its bytes but drops the data when not halted or when read protected.
// - block transfers carry a 16-bit count of 1 to 65536 bytes, zero meaning 65536.
// - 0BH returns FFH for each byte when not halted or when read protected.
// - 0CH takes 1 to 65536 data bytes but drops them when not halted or when read protected.
`timescale 1ns/1ps
module debug_command_interpreter #(
   parameter logic [15:0] REV_WORD   = 16'h0100, // arbitrary value
   parameter int          FIFO_DEPTH = dbg_pkg::RESP_FIFO_DEPTH
) (
   input  wire logic             clock_i,
   input  wire logic             rstn_i,
   input  wire logic             ce_i,
   input  wire logic             host_valid_i,
   input  wire logic [7:0]       host_data_i,
   output logic                  host_ready_o,
   output logic                  tx_valid_o,
   output logic [7:0]            tx_data_o,
   input  wire logic             tx_ready_i,
   input  wire logic             read_protect_i,
   input  wire logic [7:0]       debug_status_byte_i,
   input  wire logic             breakpoint_i,
   output dbg_pkg::mem_req_t     mem_req_o,
   input  wire logic             mem_ack_i,
   input  wire logic [7:0]       mem_rdata_i,
   output logic                  stuff_valid_o,
   output logic [7:0]            stuff_data_o,
   output logic                  exec_o,
   output logic [7:0]            debug_control_byte_o
);
   import dbg_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE, S_ARGS, S_WDATA, S_WMEM, S_RMEM, S_RPUSH, S_REPLY
   } state_t;

   state_t      state_r;
   logic [7:0]  cmd_r;
   logic [2:0]  argc_r;
   logic [15:0] addr_r;
   logic [15:0] size_r;
   logic [16:0] left_r;
   logic [15:0] reply_r;
   logic [1:0]  reply_cnt_r;
   logic [7:0]  rbyte_r;
   logic [7:0]  ctl_r;
   logic [15:0] runtime_r;
   logic        host_ready_r;
   mem_req_t    mem_req_r;
   logic        stuff_valid_r;
   logic [7:0]  stuff_data_r;
   logic        exec_r;

   logic        take;
   logic        push_valid;
   logic [7:0]  push_data;
   logic        fifo_in_ready;
   logic        push_done;
   logic        one_arg;
   logic        wr_cmd;
   logic        wr_ok;
   logic        rd_ok;
   logic        ack_ok;
   logic        last;
   logic        overwrite;

   assign take       = host_valid_i && host_ready_r && ce_i;
   assign push_valid = (state_r == S_REPLY) || (state_r == S_RPUSH);
   assign push_data  = (state_r == S_REPLY) ? reply_r[15:8] : rbyte_r;
   assign push_done  = push_valid && fifo_in_ready && ce_i;
   assign one_arg    = (cmd_r == CMD_CTL_WR) || (cmd_r == CMD_STUFF);
   assign wr_cmd     = (cmd_r == CMD_PGM_WR) || (cmd_r == CMD_DAT_WR);
   assign wr_ok      = ctl_r[HALT_BIT] && !read_protect_i;
   assign rd_ok      = (cmd_r == CMD_DAT_RD) ? ctl_r[HALT_BIT] : wr_ok;
   assign ack_ok     = mem_ack_i && mem_req_r.req;
   assign last       = (left_r == 17'h00001);
   assign overwrite  = (state_r == S_WDATA) || (state_r == S_WMEM) || (state_r == S_RMEM)
                       || (state_r == S_RPUSH) || stuff_valid_r || exec_r;

   assign host_ready_o         = host_ready_r;
   assign mem_req_o            = mem_req_r;
   assign stuff_valid_o        = stuff_valid_r;
   assign stuff_data_o         = stuff_data_r;
   assign exec_o               = exec_r;
   assign debug_control_byte_o = ctl_r;

   ////////////////////////////////////////////////////////////////////////////
   // command sequencer
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         state_r     <= S_IDLE;
         cmd_r       <= 8'h00;
         argc_r      <= 3'h0;
         addr_r      <= 16'h0000;
         size_r      <= 16'h0000;
         left_r      <= 17'h00000;
         reply_r     <= 16'h0000;
         reply_cnt_r <= 2'h0;
         rbyte_r     <= 8'h00;
      end else if (ce_i) begin
         unique case (state_r)
            S_IDLE: begin
               if (take) begin
                  cmd_r  <= host_data_i;
                  argc_r <= 3'h0;
                  case (host_data_i)
                     CMD_REV: begin
                        reply_r     <= REV_WORD;
                        reply_cnt_r <= REPLY_TWO;
                        state_r     <= S_REPLY;
                     end
                     CMD_STAT: begin
                        reply_r     <= {debug_status_byte_i, 8'h00};
                        reply_cnt_r <= REPLY_ONE;
                        state_r     <= S_REPLY;
                     end
                     CMD_RUNTIME: begin
                        reply_r     <= runtime_r;
                        reply_cnt_r <= REPLY_TWO;
                        state_r     <= S_REPLY;
                     end
                     CMD_CTL_RD: begin
                        reply_r     <= {ctl_r, 8'h00};
                        reply_cnt_r <= REPLY_ONE;
                        state_r     <= S_REPLY;
                     end
                     CMD_CTL_WR, CMD_STUFF, CMD_PGM_WR, CMD_PGM_RD, CMD_DAT_WR, CMD_DAT_RD: begin
                        state_r <= S_ARGS;
                     end
                     default: begin
                        state_r <= S_IDLE;
                     end
                  endcase
               end
            end
            S_ARGS: begin
               if (take) begin
                  argc_r <= argc_r + 3'h1;
                  {addr_r, size_r} <= {addr_r[7:0], size_r, host_data_i};
                  if (one_arg) begin
                     state_r <= S_IDLE;
                  end else if (argc_r == MEM_ARG_LAST) begin
                     left_r  <= ({size_r[7:0], host_data_i} == 16'h0000) ? MEM_MAX_COUNT
                                : {1'b0, size_r[7:0], host_data_i};
                     state_r <= wr_cmd ? S_WDATA : S_RMEM;
                  end
               end
            end
            S_WDATA: begin
               if (take) begin
                  if (wr_ok) begin
                     state_r <= S_WMEM;
                  end else begin
                     addr_r  <= addr_r + 16'h0001;
                     left_r  <= left_r - 17'h00001;
                     state_r <= last ? S_IDLE : S_WDATA;
                  end
               end
            end
            S_WMEM: begin
               if (ack_ok) begin
                  addr_r  <= addr_r + 16'h0001;
                  left_r  <= left_r - 17'h00001;
                  state_r <= last ? S_IDLE : S_WDATA;
               end
            end
            S_RMEM: begin
               if (!rd_ok && !mem_req_r.req) begin
                  rbyte_r <= BLANK_BYTE;
                  state_r <= S_RPUSH;
               end else if (ack_ok) begin
                  rbyte_r <= mem_rdata_i;
                  state_r <= S_RPUSH;
               end
            end
            S_RPUSH: begin
               if (push_done) begin
                  addr_r  <= addr_r + 16'h0001;
                  left_r  <= left_r - 17'h00001;
                  state_r <= last ? S_IDLE : S_RMEM;
               end
            end
            S_REPLY: begin
               if (push_done) begin
                  reply_r     <= {reply_r[7:0], 8'h00};
                  reply_cnt_r <= reply_cnt_r - 2'h1;
                  if (reply_cnt_r == REPLY_ONE) begin
                     state_r <= S_IDLE;
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // host byte acceptance; one byte per two cycles at most
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         host_ready_r <= 1'b0;
      end else if (ce_i) begin
         if (take) begin
            host_ready_r <= 1'b0;
         end else begin
            // bytes taken only while expecting them
            host_ready_r <= (state_r == S_IDLE) || (state_r == S_ARGS) || (state_r == S_WDATA);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control byte
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         ctl_r <= CTL_RESET;
      end else if (ce_i) begin
         if (state_r == S_ARGS && take && cmd_r == CMD_CTL_WR) begin
            ctl_r[6:0]      <= host_data_i[6:0];
            ctl_r[HALT_BIT] <= host_data_i[HALT_BIT] || (read_protect_i && ctl_r[HALT_BIT]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // memory requests, held until acknowledged
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         mem_req_r <= '0;
      end else if (ce_i) begin
         if (ack_ok) begin
            mem_req_r.req <= 1'b0;
         end else if (state_r == S_WDATA && take && wr_ok) begin
            mem_req_r.req        <= 1'b1;
            mem_req_r.we         <= 1'b1;
            mem_req_r.space_data <= (cmd_r == CMD_DAT_WR);
            mem_req_r.addr       <= addr_r;
            mem_req_r.wdata      <= host_data_i;
         end else if (state_r == S_RMEM && rd_ok && !mem_req_r.req) begin
            mem_req_r.req        <= 1'b1;
            mem_req_r.we         <= 1'b0;
            mem_req_r.space_data <= (cmd_r == CMD_DAT_RD);
            mem_req_r.addr       <= addr_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // instruction stuff and execute pulses
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         stuff_valid_r <= 1'b0;
         stuff_data_r  <= 8'h00;
         exec_r        <= 1'b0;
      end else if (ce_i) begin
         stuff_valid_r <= state_r == S_ARGS && take && cmd_r == CMD_STUFF && !read_protect_i;
         exec_r        <= state_r == S_IDLE && take && host_data_i == CMD_EXEC && !read_protect_i;
         if (state_r == S_ARGS && take && cmd_r == CMD_STUFF) begin
            stuff_data_r <= host_data_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // runtime counter
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         runtime_r <= RUNTIME_START;
      end else if (ce_i) begin
         if (overwrite || breakpoint_i) begin
            runtime_r <= RUNTIME_START;
         end else if (runtime_r != RUNTIME_MAX) begin
            runtime_r <= runtime_r + 16'h0001;
         end
      end
   end

   resp_fifo #(
      .WIDTH (RESP_FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_resp_fifo (
      .clock_i     (clock_i),
      .rstn_i      (rstn_i),
      .ce_i        (ce_i),
      .in_valid_i  (push_valid),
      .in_data_i   (push_data),
      .in_ready_o  (fifo_in_ready),
      .out_valid_o (tx_valid_o),
      .out_data_o  (tx_data_o),
      .out_ready_i (tx_ready_i)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   counter_sat_a: assert property (
      ce_i && !overwrite && !breakpoint_i && runtime_r == RUNTIME_MAX |=> runtime_r == RUNTIME_MAX)
      else $error("runtime counter left its maximum");
   counter_inc_a: assert property (
      ce_i && !overwrite && !breakpoint_i && runtime_r != RUNTIME_MAX
      |=> runtime_r == 16'($past(runtime_r) + 16'h0001))
      else $error("runtime counter did not step by one");
   counter_over_a: assert property (
      ce_i && (state_r == S_RMEM || state_r == S_WMEM) |=> runtime_r == RUNTIME_START)
      else $error("runtime counter kept counting during memory command");
   halt_sticky_a: assert property (
      read_protect_i && ctl_r[HALT_BIT] |=> ctl_r[HALT_BIT])
      else $error("halt flag cleared while protected");
   ctl_load_a: assert property (
      state_r == S_ARGS && take && cmd_r == CMD_CTL_WR
      |=> ctl_r[6:0] == $past(host_data_i[6:0]) && state_r == S_IDLE)
      else $error("control byte not loaded from operand");
   wr_discard_a: assert property (
      state_r == S_WDATA && take && !wr_ok && !mem_req_r.req |=> !mem_req_r.req)
      else $error("blocked write reached memory");
   rd_blank_a: assert property (
      ce_i && state_r == S_RMEM && !rd_ok && !mem_req_r.req
      |=> state_r == S_RPUSH && push_data == BLANK_BYTE)
      else $error("blocked read did not answer FFH");
   rsvd_ignore_a: assert property (
      state_r == S_IDLE && take && host_data_i >= CMD_RSVD_FIRST
      |=> state_r == S_IDLE && ctl_r == $past(ctl_r) && !mem_req_r.req)
      else $error("reserved command changed state");
   stuff_refuse_a: assert property (
      $past(ce_i) && (stuff_valid_r || exec_r) |-> !$past(read_protect_i))
      else $error("stuff or execute ran under protection");
   rev_order_a: assert property (
      state_r == S_IDLE && take && host_data_i == CMD_REV
      |=> reply_r == REV_WORD && reply_cnt_r == REPLY_TWO)
      else $error("revision reply not loaded major first");

   rev_read_c: cover property (state_r == S_REPLY && cmd_r == CMD_REV && push_done);
   mem_read_c: cover property (state_r == S_RPUSH && rd_ok && push_done && last);
   mem_write_c: cover property (state_r == S_WMEM && ack_ok && last);
   stuff_c: cover property (stuff_valid_r);

endmodule

// ### testbench/debug_host_model.sv
`timescale 1ns/1ps
module debug_host_model (
   input  wire logic       clock_i,
   output logic            valid_o,
   output logic [7:0]      data_o,
   input  wire logic       ready_i,
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   output logic            tx_ready_o
);
   // handshakes that never completed within the wait limit
   int timeouts;
   initial begin
      valid_o = 1'b0;
      data_o = 8'h00;
      tx_ready_o = 1'b0;
   end
   task automatic send(input logic [7:0] b);
      int n;
      n = 0;
      valid_o = 1'b1;
      data_o = b;
      while (ready_i !== 1'b1 && n < 300) begin
         @(posedge clock_i) #1;
         n++;
      end
      if (n == 300) timeouts++;
      @(posedge clock_i) #1;
      valid_o = 1'b0;
      data_o = ~b;
      // let an edge pass so the next byte never re-raises valid in this step
      @(posedge clock_i) #1;
   endtask
   // reply byte taken at one edge
   task automatic get(output logic [7:0] b);
      int n;
      n = 0;
      while (tx_valid_i !== 1'b1 && n < 300) begin
         @(posedge clock_i) #1;
         n++;
      end
      if (n == 300) timeouts++;
      tx_ready_o = 1'b1;
      b = tx_data_i;
      @(posedge clock_i) #1;
      tx_ready_o = 1'b0;
      @(posedge clock_i) #1;
   endtask
   // address then count, high byte first
   task automatic mem_cmd(input logic [7:0] c, input logic [15:0] a, input logic [15:0] sz);
      send(c);
      send(a[15:8]);
      send(a[7:0]);
      send(sz[15:8]);
      send(sz[7:0]);
   endtask
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import dbg_pkg::*;
   localparam logic [15:0] REV = 16'hA51C; // arbitrary value
   logic       clock_i, rstn_i, host_valid, host_ready, tx_valid, tx_ready;
   logic       read_protect, breakpoint, mem_ack, stuff_valid, exec_p, ce;
   logic [7:0] host_data, tx_data, stuff_data, ctl, mem_rdata, b, stat;
   mem_req_t   mem_req;
   logic [7:0] mem [logic [16:0]];
   int         bad_count, checks_done, writes, reqs, stuffs, execs, wait_cnt;
   debug_command_interpreter #(.REV_WORD(REV), .FIFO_DEPTH(RESP_FIFO_DEPTH)) dut (
      .clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce),
      .host_valid_i(host_valid), .host_data_i(host_data), .host_ready_o(host_ready),
      .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
      .read_protect_i(read_protect), .debug_status_byte_i(stat),
      .breakpoint_i(breakpoint), .mem_req_o(mem_req), .mem_ack_i(mem_ack),
      .mem_rdata_i(mem_rdata), .stuff_valid_o(stuff_valid), .stuff_data_o(stuff_data),
      .exec_o(exec_p), .debug_control_byte_o(ctl));
   debug_host_model host (
      .clock_i(clock_i), .valid_o(host_valid), .data_o(host_data), .ready_i(host_ready),
      .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready));
   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end
   ////////////////////////////////////////////////////////////////
   // memory responder: ack after three cycles, keyed by space and address
   always begin
      @(posedge clock_i) #1;
      mem_ack = 1'b0;
      mem_rdata = ~mem_rdata;
      if (mem_req.req === 1'b1) begin
         wait_cnt++;
         if (wait_cnt == 3) begin
            wait_cnt = 0;
            mem_ack = 1'b1;
            reqs++;
            if (mem_req.we) begin
               mem[{mem_req.space_data, mem_req.addr}] = mem_req.wdata;
               writes++;
            end else if (mem.exists({mem_req.space_data, mem_req.addr})) begin
               mem_rdata = mem[{mem_req.space_data, mem_req.addr}];
            end else begin
               mem_rdata = mem_req.addr[7:0];
            end
         end
      end
   end
   always @(posedge clock_i) begin
      if (stuff_valid === 1'b1) stuffs++;
      if (exec_p === 1'b1) execs++;
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic rd_ctl(input logic [7:0] e);
      host.send(CMD_CTL_RD);
      host.get(b);
      chk(e, b);
      chk(e, ctl);
   endtask
   task automatic t_runtime;
      repeat (66000) @(posedge clock_i);
      #1 host.send(CMD_RUNTIME);
      host.get(b);
      chk(8'hFF, b);
      host.get(b);
      chk(8'hFF, b);
      breakpoint = 1'b1;
      @(posedge clock_i) #1;
      breakpoint = 1'b0;
      host.send(CMD_RUNTIME);
      host.get(b);
      chk(8'h00, b);
      host.get(b);
      chk(8'h00, b);
      $display("test runtime done");
   endtask
   task automatic t_regs;
      host.send(CMD_REV);
      host.get(b);
      chk(REV[15:8], b);
      host.get(b);
      chk(REV[7:0], b);
      host.send(CMD_STAT);
      host.get(b);
      chk(stat, b);
      stat = 8'h69;
      host.send(CMD_STAT);
      host.get(b);
      chk(stat, b);
      host.send(CMD_CTL_WR);
      host.send(8'h5A);
      rd_ctl(8'h5A);
      host.send(8'h13);
      host.send(8'hFF);
      host.send(8'h01);
      rd_ctl(8'h5A);
      chk(0, stuffs + execs + reqs);
      $display("test registers done");
   endtask
   // a reply offered while frozen must not be lost
   task automatic t_freeze;
      host.send(CMD_REV);
      repeat (4) @(posedge clock_i) #1;
      ce = 1'b0;
      host.get(b);
      chk(REV[15:8], b);
      ce = 1'b1;
      host.get(b);
      chk(REV[15:8], b);
      host.get(b);
      chk(REV[7:0], b);
      $display("test clock enable done");
   endtask
   task automatic t_mem;
      host.send(CMD_CTL_WR);
      host.send(8'h80);
      host.mem_cmd(CMD_DAT_WR, 16'h1234, 16'h0001);
      host.send(8'hA5);
      repeat (8) @(posedge clock_i) #1;
      chk(8'hA5, mem[17'h11234]);
      host.mem_cmd(CMD_DAT_RD, 16'h1234, 16'h0002);
      host.get(b);
      chk(8'hA5, b);
      host.get(b);
      chk(8'h35, b);
      host.mem_cmd(CMD_PGM_WR, 16'h0040, 16'h0001);
      host.send(8'h77);
      host.mem_cmd(CMD_PGM_RD, 16'h0040, 16'h0001);
      host.get(b);
      chk(8'h77, b);
      host.send(CMD_CTL_WR);
      host.send(8'h00);
      host.mem_cmd(CMD_PGM_WR, 16'h0040, 16'h0001);
      host.send(8'h11);
      host.mem_cmd(CMD_PGM_RD, 16'h0040, 16'h0003);
      repeat (3) begin
         host.get(b);
         chk(BLANK_BYTE, b);
      end
      chk(5, reqs);
      $display("test memory done");
   endtask
   task automatic t_prot;
      read_protect = 1'b1;
      host.send(CMD_CTL_WR);
      host.send(8'h80);
      host.send(CMD_CTL_WR);
      host.send(8'h00);
      rd_ctl(8'h80);
      host.mem_cmd(CMD_DAT_WR, 16'h0050, 16'h0001);
      host.send(8'h22);
      host.mem_cmd(CMD_PGM_RD, 16'h0040, 16'h0001);
      host.get(b);
      chk(BLANK_BYTE, b);
      host.send(CMD_STUFF);
      host.send(8'h3C);
      host.send(CMD_EXEC);
      repeat (4) @(posedge clock_i) #1;
      chk(0, stuffs + execs);
      chk(5, reqs);
      read_protect = 1'b0;
      host.send(CMD_STUFF);
      host.send(8'h3C);
      host.send(CMD_EXEC);
      repeat (4) @(posedge clock_i) #1;
      chk(16'h0101, {stuffs[7:0], execs[7:0]});
      chk(8'h3C, stuff_data);
      rstn_i = 1'b0;
      repeat (2) @(posedge clock_i);
      #1 rstn_i = 1'b1;
      rd_ctl(CTL_RESET);
      $display("test protection done");
   endtask
   initial begin
      rstn_i = 1'b0;
      ce = 1'b1;
      read_protect = 1'b0;
      breakpoint = 1'b0;
      mem_ack = 1'b0;
      mem_rdata = 8'h00;
      stat = 8'h96;
      repeat (2) @(posedge clock_i);
      #1 rstn_i = 1'b1;
      t_runtime();
      t_regs();
      t_freeze();
      t_mem();
      t_prot();
      chk(0, host.timeouts);
      report_and_stop();
   end
   initial begin
      #300000;
      bad_count++;
      report_and_stop();
   end
endmodule
